// ---- common/sadc_pkg.sv ----
// shared constants and carrier types for the serial sar converter block
// assumes: system side on clk_sys_i, link side on the falling edge of serial_bit_clock_i
package sadc_pkg;

   // ------------------------------------------------------------
   // result word and buffering
   // ------------------------------------------------------------
   localparam int              RESULT_BITS  = 12;
   localparam int              FIFO_DEPTH   = 8;
   localparam int              EDGE_W       = 5;
   localparam logic [11:0]     RESULT_ZERO  = 12'h000;
   localparam logic [11:0]     RESULT_ONE   = 12'h001;

   // ------------------------------------------------------------
   // falling bit-clock edge numbers inside one frame (first edge is 1)
   // ------------------------------------------------------------
   localparam logic [4:0]      EDGE_ZERO        = 5'h00;
   localparam logic [4:0]      EDGE_STEP        = 5'h01;
   localparam logic [4:0]      EDGE_NULL        = 5'h02;  // output enabled, low null bit
   localparam logic [4:0]      EDGE_MSB         = 5'h03;  // first decision, bit 11
   localparam logic [4:0]      EDGE_LSB         = 5'h0e;  // last decision, bit 0
   localparam logic [4:0]      EDGE_REPEAT_LAST = 5'h19;  // bit 11 repeated
   localparam logic [4:0]      EDGE_TRISTATE    = 5'h1a;  // output released, clocks ignored

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int              SYS_PERIOD_NS       = 20;
   localparam int              DECISION_TIME_NS    = 830;
   // longest time, so it rounds down
   localparam int              DECISION_SYS_CYCLES = DECISION_TIME_NS / SYS_PERIOD_NS;

   // ------------------------------------------------------------
   // carriers and states
   // ------------------------------------------------------------
   typedef struct packed {
      logic [11:0] level;
   } sadc_sample_t;

   typedef struct packed {
      logic analog_on;
      logic digital_on;
   } sadc_power_t;

   typedef enum {
      SADC_LOAD,
      SADC_OFFER,
      SADC_RELEASE
   } sadc_hold_state_t;

endpackage : sadc_pkg

// ---- core/sadc_sync.sv ----
// two-flop synchroniser for levels entering the system clock domain
// assumes: inputs are quasi-static levels, never multi-bit words that change together
`timescale 1ns/100ps
module sadc_sync
   import sadc_pkg::*;
#(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             clk_sys_i,
   input  wire logic             reset_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // ------------------------------------------------------------
   // two stages; the first is read by the second only
   // ------------------------------------------------------------
   // the reset value matches the idle level of the pin, so no false change
   // appears at the output when reset is released
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         meta   <= RESET_VALUE;
         sync_o <= RESET_VALUE;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule : sadc_sync

// ---- core/sadc_fifo.sv ----
// synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-low reset
`timescale 1ns/100ps
module sadc_fifo
   import sadc_pkg::*;
#(
   parameter int WIDTH = RESULT_BITS,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk_sys_i,
   input  wire logic             reset_n_i,
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   output logic                  out_valid_o,
   output logic      [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);

   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0]   count;
   logic [PTR_W:0]   next_count;
   logic             push;
   logic             pop;

   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];

   // ------------------------------------------------------------
   // occupancy; ready is registered so the source sees a clean level
   // ------------------------------------------------------------
   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         count      <= '0;
         in_ready_o <= 1'b0;
      end else begin
         count      <= next_count;
         in_ready_o <= (next_count != (PTR_W+1)'(DEPTH));
      end
   end

   // pointers wrap naturally, depth is a power of two
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   // storage has no reset, it is only read when count says valid
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

endmodule : sadc_fifo

// ---- core/sadc_top.sv ----
// serial successive-approximation converter core: sample hand-off, bit decisions,
// serial readout and power states
// assumes: the host drives select_n_i and serial_bit_clock_i; the bit clock may stop
// outside frames; the analog level arrives as a digital stream on clk_sys_i
// power_o lags its cause by three system clocks: two synchroniser flops and one output flop
`timescale 1ns/100ps

// Contract
// - analog off after conversion or select high
// - digital fully off only while select high
// - select low after conversion: partial power only
// - each bit driven as soon as decided
// - select high aborts, enters full power down
// - one decision and output update per clock
// - select falling edge starts a cycle
// - null bit, then twelve bits msb first
// - repeat lsb first, then tristate, ignore clocks
module sadc_top
   import sadc_pkg::*;
(
   input  wire logic         clk_sys_i,
   input  wire logic         reset_n_i,
   input  wire logic         sample_valid_i,
   input  wire sadc_sample_t sample_i,
   output logic              sample_ready_o,
   input  wire logic         select_n_i,
   input  wire logic         serial_bit_clock_i,
   output logic              serial_data_o,
   output logic              serial_data_oe_o,
   output sadc_power_t       power_o
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   // system side
   sadc_hold_state_t state;
   logic             fifo_valid;
   logic [11:0]      fifo_level;
   logic             fifo_take;
   logic             offer_req;
   logic [11:0]      hold_level;
   logic             ack_seen;
   // crossings into the system clock
   logic             select_n_seen;
   logic             done_seen;

   // link side
   logic [4:0]       edge_cnt;
   logic [4:0]       next_edge;
   logic             req_meta;
   logic             req_seen;
   logic             link_ack;
   logic [11:0]      held_level;
   logic [11:0]      sar_result;
   logic [11:0]      compare_level;
   logic [11:0]      trial;
   logic [3:0]       decide_idx;
   logic [3:0]       repeat_idx;
   logic             decision;
   logic             is_decision_edge;
   logic             is_repeat_edge;
   logic             conv_done;

   // ------------------------------------------------------------
   // system side: sample buffer
   // ------------------------------------------------------------
   // eight samples of look-ahead; when no frames run the buffer fills
   // and sample_ready_o drops, stalling the source
   sadc_fifo #(
      .WIDTH (RESULT_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (sample_valid_i),
      .in_data_i   (sample_i.level),
      .in_ready_o  (sample_ready_o),
      .out_valid_o (fifo_valid),
      .out_data_o  (fifo_level),
      .out_ready_i (fifo_take)
   );

   assign fifo_take = (state == SADC_LOAD) && fifo_valid;

   // ------------------------------------------------------------
   // system side: four-phase offer of one level to the link
   // ------------------------------------------------------------
   // the four-phase offer costs a few system clocks after every frame; a frame
   // that starts before the next level is offered converts zero instead
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         state <= SADC_LOAD;
      end else begin
         unique case (state)
            SADC_LOAD: begin
               if (fifo_valid) begin
                  state <= SADC_OFFER;
               end
            end
            SADC_OFFER: begin
               // a frame ended before its ack was seen keeps offering the same level
               if (ack_seen) begin
                  state <= SADC_RELEASE;
               end
            end
            SADC_RELEASE: begin
               // ack falls when select rises; only then may a new level be offered
               if (!ack_seen) begin
                  state <= SADC_LOAD;
               end
            end
         endcase
      end
   end

   // request level: raised with a fresh level, lowered once the link has acknowledged
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         offer_req <= 1'b0;
      end else if (fifo_take) begin
         offer_req <= 1'b1;
      end else if (state == SADC_OFFER && ack_seen) begin
         offer_req <= 1'b0;
      end
   end

   // hold_level only changes while offer_req is low, so the link may read
   // it directly once it has seen the request through its synchroniser
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         hold_level <= RESULT_ZERO;
      end else if (fifo_take) begin
         hold_level <= fifo_level;
      end
   end

   // ------------------------------------------------------------
   // system side: crossings from the link
   // ------------------------------------------------------------
   sadc_sync #(
      .WIDTH (1)
   ) u_ack_sync (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .async_i   (link_ack),
      .sync_o    (ack_seen)
   );

   // the raw select pin and the link's done flag each cross on their own two
   // flops and are combined only afterwards: no gate sits in front of a
   // synchroniser, so a glitch of the edge counter can never pass as a power change;
   // the select pin idles high, so its synchroniser resets high
   sadc_sync #(
      .WIDTH       (1),
      .RESET_VALUE (1'b1)
   ) u_select_sync (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .async_i   (select_n_i),
      .sync_o    (select_n_seen)
   );

   sadc_sync #(
      .WIDTH (1)
   ) u_done_sync (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .async_i   (conv_done),
      .sync_o    (done_seen)
   );

   // comparator power follows the select pin, so it rises at the select fall
   // without waiting for a bit clock; the output flop costs one cycle of latency
   // but keeps power_o straight from a register
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         power_o <= '0;
      end else begin
         power_o.analog_on  <= !select_n_seen && !done_seen;
         power_o.digital_on <= !select_n_seen;
      end
   end

   // ------------------------------------------------------------
   // link side: frame edge counter
   // ------------------------------------------------------------
   // select high holds every link flop cleared: that is the full power down,
   // and a new frame can only begin after select has gone high and low again
   always_ff @(negedge serial_bit_clock_i or posedge select_n_i) begin
      if (select_n_i) begin
         edge_cnt <= EDGE_ZERO;
      end else if (edge_cnt != EDGE_TRISTATE) begin
         edge_cnt <= next_edge;
      end
   end

   // number of the falling edge about to arrive
   assign next_edge = edge_cnt + EDGE_STEP;

   // done flag for the power crossing: a single flop that changes once per
   // frame, set by the last decision and cleared by select high
   always_ff @(negedge serial_bit_clock_i or posedge select_n_i) begin
      if (select_n_i) begin
         conv_done <= 1'b0;
      end else if (next_edge == EDGE_LSB) begin
         conv_done <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // link side: request synchroniser and acknowledge
   // ------------------------------------------------------------
   // two edges of sampling time cover the two synchroniser stages
   always_ff @(negedge serial_bit_clock_i or posedge select_n_i) begin
      if (select_n_i) begin
         req_meta <= 1'b0;
         req_seen <= 1'b0;
      end else begin
         req_meta <= offer_req;
         req_seen <= req_meta;
      end
   end

   // ack is held for the rest of the frame and dropped by select high
   always_ff @(negedge serial_bit_clock_i or posedge select_n_i) begin
      if (select_n_i) begin
         link_ack <= 1'b0;
      end else if (next_edge == EDGE_MSB && req_seen) begin
         link_ack <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // link side: successive approximation
   // ------------------------------------------------------------
   // with no level on offer at the end of sampling the frame converts zero;
   // the compare is ideal, a level equal to the trial keeps the bit
   always_comb begin
      is_decision_edge = (next_edge >= EDGE_MSB) && (next_edge <= EDGE_LSB);
      is_repeat_edge   = (next_edge > EDGE_LSB) && (next_edge <= EDGE_REPEAT_LAST);
      decide_idx       = 4'(EDGE_LSB - next_edge);
      repeat_idx       = 4'(next_edge - EDGE_LSB);
      if (next_edge == EDGE_MSB) begin
         compare_level = req_seen ? hold_level : RESULT_ZERO;
      end else begin
         compare_level = held_level;
      end
      trial    = sar_result | (RESULT_ONE << decide_idx);
      decision = (compare_level >= trial);
   end

   // one bit decision per falling edge; the level is held from the first one
   always_ff @(negedge serial_bit_clock_i or posedge select_n_i) begin
      if (select_n_i) begin
         held_level <= RESULT_ZERO;
         sar_result <= RESULT_ZERO;
      end else if (is_decision_edge) begin
         held_level             <= compare_level;
         sar_result[decide_idx] <= decision;
      end
   end

   // ------------------------------------------------------------
   // link side: serial output pin
   // ------------------------------------------------------------
   // the decision goes to the pin on the same edge that makes it, so a host
   // that stops early already holds valid upper bits
   always_ff @(negedge serial_bit_clock_i or posedge select_n_i) begin
      if (select_n_i) begin
         serial_data_o <= 1'b0;
      end else if (next_edge == EDGE_NULL) begin
         serial_data_o <= 1'b0;
      end else if (is_decision_edge) begin
         serial_data_o <= decision;
      end else if (is_repeat_edge) begin
         serial_data_o <= sar_result[repeat_idx];
      end else if (next_edge == EDGE_TRISTATE) begin
         serial_data_o <= 1'b0;
      end
   end

   // enable: on from the null bit until the repeated msb has gone out;
   // later clocks find no matching edge number and leave it off
   always_ff @(negedge serial_bit_clock_i or posedge select_n_i) begin
      if (select_n_i) begin
         serial_data_oe_o <= 1'b0;
      end else if (next_edge == EDGE_NULL) begin
         serial_data_oe_o <= 1'b1;
      end else if (next_edge == EDGE_TRISTATE) begin
         serial_data_oe_o <= 1'b0;
      end
   end

endmodule : sadc_top

// ---- verification/sadc_host_model.sv ----
// host model: drives select and the serial bit clock, samples data on rising edges
// assumes: 30 ns bit clock that runs only inside frames; the testbench calls frame()
`timescale 1ns/100ps
module sadc_host_model (
   input  wire logic        data_i,
   input  wire logic        oe_i,
   output logic             select_n_o,
   output logic             bit_clk_o,
   output logic             done_o,
   output logic [31:0]      bits_o,
   output logic [31:0]      oe_o
);
   logic last_q;
   // a released pin shows the inverse of its last driven level, never a stale copy
   wire  line = oe_i ? data_i : ~last_q;
   always @(data_i or oe_i) begin
      if (oe_i) last_q = data_i;
   end
   // idle: select high, clock low
   initial begin
      select_n_o = 1'b1;
      bit_clk_o  = 1'b0;
      done_o     = 1'b0;
      last_q     = 1'b0;
   end
   // one frame of n falling edges; n below 14 short-cycles the conversion
   task automatic frame(input int n);
      bits_o     = '0;
      oe_o       = '0;
      #3;                                      // keeps every link change off the system clock edges
      select_n_o = 1'b0;
      for (int k = 0; k <= n; k++) begin
         #(k == 0 ? 30 : 15);
         bit_clk_o = 1'b1;
         bits_o[k] = line;                     // rising edge takes bit k
         oe_o[k]   = oe_i;
         #15;
         if (k < n) bit_clk_o = 1'b0;
      end
      select_n_o = 1'b1;
      #15;
      bit_clk_o = 1'b0;                        // falls with select high, so it is ignored
      done_o    = 1'b1;
      #1;
      done_o    = 1'b0;
   endtask : frame
endmodule : sadc_host_model

// ---- verification/sadc_top_assertions.sv ----
// checker for the converter core: link framing and power state timing
// assumes: bound to sadc_top; select high clears the link side
`timescale 1ns/100ps
module sadc_top_assertions
   import sadc_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        reset_n_i,
   input wire logic        select_n_i,
   input wire logic        serial_bit_clock_i,
   input wire logic        serial_data_o,
   input wire logic        serial_data_oe_o,
   input wire sadc_power_t power_o
);
   logic [4:0] edge_cnt;
   // falling edges since select fell; saturates so late clocks cannot wrap it
   always_ff @(negedge serial_bit_clock_i or posedge select_n_i) begin
      if (select_n_i) edge_cnt <= EDGE_ZERO;
      else if (edge_cnt != 5'h1f) edge_cnt <= edge_cnt + EDGE_STEP;
   end
   // ------------------------------------------------------------
   // link side, sampled one falling edge later
   // ------------------------------------------------------------
   chk_edge1_quiet: assert property (@(negedge serial_bit_clock_i) disable iff (select_n_i)
      edge_cnt == EDGE_STEP |-> !serial_data_oe_o) else $error("pin driven after first edge");
   chk_null_bit: assert property (@(negedge serial_bit_clock_i) disable iff (select_n_i)
      edge_cnt == EDGE_NULL |-> serial_data_oe_o && !serial_data_o) else $error("null bit wrong");
   chk_oe_in_frame: assert property (@(negedge serial_bit_clock_i) disable iff (select_n_i)
      edge_cnt inside {[EDGE_MSB:EDGE_REPEAT_LAST]} |-> serial_data_oe_o) else $error("pin not driven");
   chk_tristate_end: assert property (@(negedge serial_bit_clock_i) disable iff (select_n_i)
      edge_cnt >= EDGE_TRISTATE |-> !serial_data_oe_o && !serial_data_o) else $error("pin not released");
   // ------------------------------------------------------------
   // system side; power flags lag by the two-flop crossing and one output flop
   // ------------------------------------------------------------
   chk_oe_idle_sel: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      select_n_i [*2] |-> !serial_data_oe_o && !serial_data_o) else $error("pin driven while idle");
   chk_digital_off_sel: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      select_n_i [*4] |-> !power_o.digital_on) else $error("digital awake while idle");
   chk_digital_on_low: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (!select_n_i) [*4] |-> power_o.digital_on) else $error("digital asleep while selected");
   chk_analog_off_sel: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      select_n_i [*4] |-> !power_o.analog_on) else $error("analog on while idle");
   chk_analog_on_conv: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (!select_n_i && edge_cnt < EDGE_LSB) [*4] |-> power_o.analog_on) else $error("analog off early");
   chk_analog_off_done: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (!select_n_i && edge_cnt >= EDGE_LSB) [*4] |-> !power_o.analog_on) else $error("analog on late");
   cover property (@(negedge serial_bit_clock_i) edge_cnt >= EDGE_TRISTATE);
   cover property (@(posedge clk_sys_i) $rose(select_n_i) && edge_cnt == 5'h08);
   cover property (@(posedge clk_sys_i) power_o.digital_on && !power_o.analog_on);
endmodule : sadc_top_assertions

bind sadc_top sadc_top_assertions sadc_top_assertions_inst (
   .clk_sys_i          (clk_sys_i),
   .reset_n_i          (reset_n_i),
   .select_n_i         (select_n_i),
   .serial_bit_clock_i (serial_bit_clock_i),
   .serial_data_o      (serial_data_o),
   .serial_data_oe_o   (serial_data_oe_o),
   .power_o            (power_o)
);

// ---- verification/sadc_top_tb.sv ----
// testbench for the converter core: runs one frame with nothing offered, fills the buffer, then runs full and short frames
// assumes: host model drives the link; expectations queued per frame, checked on completion
`timescale 1ns/100ps
module sadc_top_tb;
   import sadc_pkg::*;
   logic         clk_sys_i, reset_n_i, sample_valid_i, sample_ready_o;
   logic         select_n_i, serial_bit_clock_i, serial_data_o, serial_data_oe_o, frame_done;
   sadc_sample_t sample_i;
   sadc_power_t  power_o;
   logic [31:0]  got_bits, got_oe;
   logic [11:0]  lvl;
   logic [11:0]  lv_q[$], exp_lv_q[$];
   int           exp_n_q[$];
   int           errors, n_compared;
   integer       seed;
   int           lens_tab[11] = '{26, 2, 8, 15, 30, 12, 26, 26, 26, 26, 26};

   sadc_top sadc_top_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sample_valid_i(sample_valid_i),
      .sample_i(sample_i), .sample_ready_o(sample_ready_o), .select_n_i(select_n_i),
      .serial_bit_clock_i(serial_bit_clock_i), .serial_data_o(serial_data_o),
      .serial_data_oe_o(serial_data_oe_o), .power_o(power_o));
   sadc_host_model sadc_host_model_inst (.data_i(serial_data_o), .oe_i(serial_data_oe_o),
      .select_n_o(select_n_i), .bit_clk_o(serial_bit_clock_i), .done_o(frame_done),
      .bits_o(got_bits), .oe_o(got_oe));

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic end_sim;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask : check

   // a frame of two edges aborts before the first decision, so its word stays on offer
   task automatic run(input int n);
      logic [11:0] l;
      l = (lv_q.size() > 0) ? lv_q[0] : RESULT_ZERO;
      if (n > 2 && lv_q.size() > 0) void'(lv_q.pop_front());
      exp_n_q.push_back(n);
      exp_lv_q.push_back(l);
      sadc_host_model_inst.frame(n);
      repeat (10) @(posedge clk_sys_i);  // select high while the next word reaches the offer
   endtask : run

   // result watcher: compares each finished frame with the oldest note
   always @(posedge frame_done) begin : monitor
      int          n;
      logic [11:0] l;
      n = exp_n_q.pop_front();
      l = exp_lv_q.pop_front();
      for (int k = 2; k <= n; k++) begin
         if (k <= 25) check(got_oe[k], 1'b1, "pin enabled");
         if (k == 2) check(got_bits[k], 1'b0, "null bit");
         else if (k <= 14) check(got_bits[k], l[14-k], "decision bit");
         else if (k <= 25) check(got_bits[k], l[k-14], "repeat bit");
         else check(got_oe[k], 1'b0, "released pin");
      end
      $display("frame of %0d edges done", n);
   end

   initial begin : main
      int k;
      seed           = 32'hbe28_9194;
      reset_n_i      = 1'b0;
      sample_valid_i = 1'b0;
      sample_i       = '0;
      repeat (4) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      run(26);  // nothing offered yet, so the result is zero
      // fill the buffer until it refuses
      for (k = 0; k < 16; k++) begin
         lvl = 12'($random(seed));
         sample_valid_i <= 1'b1;
         sample_i       <= '{level: lvl};
         @(posedge clk_sys_i);
         if (sample_ready_o !== 1'b1) break;
         lv_q.push_back(lvl);
      end
      sample_valid_i <= 1'b0;
      check(sample_ready_o, 1'b0, "buffer full");
      $display("buffer fill done, %0d words", lv_q.size());
      // full, aborted, short-cycled, sixteen-clock and over-clocked frames
      foreach (lens_tab[i]) run(lens_tab[i]);
      for (k = 0; k < 100 && exp_n_q.size() > 0; k++) @(posedge clk_sys_i);
      if (exp_n_q.size() > 0) begin
         errors++;
         $display("[ERR] %0t frames left unchecked", $time);
      end
      end_sim();
   end

endmodule : sadc_top_tb
